// ===== hdl/dual_serial_register_port.sv
// Slave register access port over I2C or 3/4-wire SPI, sharing one set of pads
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.svh"

module dual_serial_register_port
  import serial_port_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       cs_pin,
  input  wire logic       scl_pin,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic       sdo_in,
  output var  logic       sdo_out,
  output var  logic       sdo_oe,
  output var  logic [6:0] rd_addr,
  input  wire logic [7:0] rd_data,
  output var  logic       rd_strobe,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic      [6:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic            three_wire_select,
  output logic            addr_auto_increment
);

  // Pin synchronisers; stage 1 feeds stage 2 only, stage 3 is for edges
  logic [1:0] cs_sync_r;            // Mode select needs no edge stage
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic [1:0] lsb_sync_r;

  // Protocol state
  port_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;       // Bit count within a byte
  logic       ack_r, ack_nxt;       // In acknowledge slot
  logic [7:0] sh_r, sh_nxt;         // Shift register
  logic [6:0] ptr_r, ptr_nxt;       // Register address
  logic       rw_r, rw_nxt;         // Direction, 1 = read
  logic       hdr_r, hdr_nxt;       // SPI command byte done
  logic       nak_r, nak_nxt;       // Master refused last byte
  logic       tx_en_r, tx_en_nxt;   // Device owns data line
  logic       tx_bit_r, tx_bit_nxt; // Bit being presented
  logic       strobe_nxt;
  logic       sda_out_nxt, sda_oe_nxt, sdo_out_nxt, sdo_oe_nxt;

  // Local control registers
  logic [7:0] ctrl1_r, ctrl1_nxt;
  logic [7:0] ctrl2_r, ctrl2_nxt;

  // Two-entry write buffer
  wr_word_t   buf_r [2];
  wr_word_t   buf_nxt [2];
  logic       head_r, head_nxt;
  logic [1:0] count_r, count_nxt;

  // Sampled views of the pins
  logic cs_hi, scl_hi, scl_rise, scl_fall, sda_hi, start_cond, stop_cond;
  logic [6:0] own_addr;
  logic       inc;
  logic       push;
  wr_word_t   push_word;
  logic       pop;

  assign cs_hi      = cs_sync_r[1];
  assign scl_hi     = scl_sync_r[1];
  assign sda_hi     = sda_sync_r[1];
  assign scl_rise   = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall   = ~scl_sync_r[1] & scl_sync_r[2];
  assign start_cond = scl_hi & scl_sync_r[2] & ~sda_hi & sda_sync_r[2];
  assign stop_cond  = scl_hi & scl_sync_r[2] & sda_hi & ~sda_sync_r[2];
  assign own_addr   = {`I2C_ADDR_UPPER, lsb_sync_r[1]};
  assign inc        = ctrl2_r[`AUTO_INC_BIT];
  assign pop        = (count_r != 2'h0) & wr_ready;

  assign three_wire_select   = ctrl1_r[`THREE_WIRE_BIT];
  assign addr_auto_increment = ctrl2_r[`AUTO_INC_BIT];
  assign wr_valid = (count_r != 2'h0);
  assign wr_addr  = buf_r[head_r][14:8];
  assign wr_data  = buf_r[head_r][7:0];

  // Read value: local controls answer here, the rest from the user side
  function automatic logic [7:0] rd_value(input logic [6:0] a, input logic [7:0] c1,
                                          input logic [7:0] c2, input logic [7:0] ext);
    if (a == `CTRL_ONE_ADDR) begin
      rd_value = c1;
    end else if (a == `CTRL_TWO_ADDR) begin
      rd_value = c2;
    end else begin
      rd_value = ext;
    end
  endfunction

  // Double-flop every pad, the link clock included
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_r  <= 2'h3;
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      lsb_sync_r <= 2'h0;
    end else begin
      cs_sync_r  <= {cs_sync_r[0], cs_pin};
      scl_sync_r <= {scl_sync_r[1:0], scl_pin};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
      lsb_sync_r <= {lsb_sync_r[0], sdo_in};
    end
  end

  // Next-state logic for both protocols, controls and write buffer
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    ack_nxt    = ack_r;
    sh_nxt     = sh_r;
    ptr_nxt    = ptr_r;
    rw_nxt     = rw_r;
    hdr_nxt    = hdr_r;
    nak_nxt    = nak_r;
    tx_en_nxt  = tx_en_r;
    tx_bit_nxt = tx_bit_r;
    strobe_nxt = 1'b0;
    push       = 1'b0;
    push_word  = '0;
    ctrl1_nxt  = ctrl1_r;
    ctrl2_nxt  = ctrl2_r;
    if (!cs_hi) begin
      if (state_r != S_SPI) begin
        // CS just fell: fresh SPI frame, I2C abandoned
        state_nxt = S_SPI;
        cnt_nxt   = 4'h0;
        hdr_nxt   = 1'b0;
        tx_en_nxt = 1'b0;
        ack_nxt   = 1'b0;
      end else begin
        if (scl_rise) begin
          if (!(hdr_r & rw_r)) begin
            sh_nxt = {sh_r[6:0], sda_hi};
          end
          cnt_nxt = {1'b0, cnt_r[2:0] + 3'h1};
          if (cnt_r[2:0] == 3'h7) begin
            if (!hdr_r) begin
              hdr_nxt = 1'b1;
              rw_nxt  = sh_nxt[7];
              ptr_nxt = sh_nxt[6:0];
            end else if (!rw_r) begin
              push      = 1'b1;
              push_word = {ptr_r, sh_nxt};
              ptr_nxt   = ptr_r + {6'h00, inc};
            end
          end
        end
        if (scl_fall && hdr_r && rw_r) begin
          tx_en_nxt = 1'b1;
          if (cnt_r[2:0] == 3'h0) begin
            // Start of each read byte: fetch and present MSB
            sh_nxt     = rd_value(ptr_r, ctrl1_r, ctrl2_r, rd_data);
            tx_bit_nxt = sh_nxt[7];
            strobe_nxt = 1'b1;
            ptr_nxt    = ptr_r + {6'h00, inc};
          end else begin
            sh_nxt     = {sh_r[6:0], 1'b0};
            tx_bit_nxt = sh_r[6];
          end
        end
      end
    end else if (state_r == S_SPI) begin
      // CS rose: frame over, release everything
      state_nxt = S_IDLE;
      tx_en_nxt = 1'b0;
    end else if (start_cond) begin
      state_nxt = S_I2C_ADDR;
      cnt_nxt   = 4'h0;
      ack_nxt   = 1'b0;
      tx_en_nxt = 1'b0;
    end else if (stop_cond) begin
      state_nxt = S_IDLE;
      tx_en_nxt = 1'b0;
    end else if (state_r != S_IDLE) begin
      // Edge spacing at 400 kHz is dozens of sys_clk cycles
      if (scl_rise) begin
        if (ack_r) begin
          nak_nxt = sda_hi;
        end else if (cnt_r < `BYTE_BITS) begin
          if (state_r != S_I2C_RD) begin
            sh_nxt = {sh_r[6:0], sda_hi};
          end
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      if (scl_fall) begin
        if (ack_r) begin
          // End of acknowledge slot
          ack_nxt   = 1'b0;
          cnt_nxt   = 4'h0;
          tx_en_nxt = 1'b0;
          case (state_r)
            S_I2C_ADDR: begin
              state_nxt = rw_r ? S_I2C_RD : S_I2C_PTR;
            end
            S_I2C_PTR: begin
              state_nxt = S_I2C_WR;
            end
            S_I2C_RD: begin
              if (nak_r) begin
                state_nxt = S_IDLE;
              end
            end
            default: begin
            end
          endcase
          if (state_nxt == S_I2C_RD) begin
            sh_nxt     = rd_value(ptr_r, ctrl1_r, ctrl2_r, rd_data);
            tx_bit_nxt = sh_nxt[7];
            tx_en_nxt  = 1'b1;
            strobe_nxt = 1'b1;
            ptr_nxt    = ptr_r + {6'h00, inc};
          end
        end else if (cnt_r == `BYTE_BITS) begin
          // Eighth bit done: enter acknowledge slot
          ack_nxt    = 1'b1;
          tx_bit_nxt = 1'b0;
          tx_en_nxt  = 1'b1;
          case (state_r)
            S_I2C_ADDR: begin
              if (sh_r[7:1] == own_addr) begin
                rw_nxt = sh_r[0];
              end else begin
                state_nxt = S_IDLE;
                ack_nxt   = 1'b0;
                tx_en_nxt = 1'b0;
              end
            end
            S_I2C_PTR: begin
              ptr_nxt = sh_r[6:0];
            end
            S_I2C_WR: begin
              if (count_r != `BUF_DEPTH) begin
                push      = 1'b1;
                push_word = {ptr_r, sh_r};
                ptr_nxt   = ptr_r + {6'h00, inc};
              end else begin
                // Buffer full: refuse the byte rather than lose it
                state_nxt = S_IDLE;
                ack_nxt   = 1'b0;
                tx_en_nxt = 1'b0;
              end
            end
            default: begin
              tx_en_nxt = 1'b0; // Master acknowledges a read byte
            end
          endcase
        end else if (state_r == S_I2C_RD) begin
          sh_nxt     = {sh_r[6:0], 1'b0};
          tx_bit_nxt = sh_r[6];
        end
      end
    end
    // Local control registers snoop every pushed write, even one lost to a full buffer
    if (push && push_word[14:8] == `CTRL_ONE_ADDR) begin
      ctrl1_nxt = push_word[7:0];
    end
    if (push && push_word[14:8] == `CTRL_TWO_ADDR) begin
      ctrl2_nxt = push_word[7:0];
    end
    // Two-entry buffer; SPI cannot stall, so a push into a full buffer is lost
    buf_nxt   = buf_r;
    head_nxt  = head_r ^ pop;
    count_nxt = count_r;
    if (push && count_r != `BUF_DEPTH) begin
      buf_nxt[head_r ^ count_r[0]] = push_word;
      count_nxt = count_r + 2'h1;
    end
    if (pop) begin
      count_nxt = count_nxt - 2'h1;
    end
    // Pad drive: I2C open drain, SPI on SERIAL_DATA_OUT or shared data pin
    if (state_nxt == S_SPI) begin
      sda_oe_nxt  = tx_en_nxt & ctrl1_r[`THREE_WIRE_BIT];
      sda_out_nxt = tx_bit_nxt;
      sdo_oe_nxt  = tx_en_nxt & ~ctrl1_r[`THREE_WIRE_BIT];
    end else begin
      sda_oe_nxt  = tx_en_nxt & ~tx_bit_nxt;
      sda_out_nxt = 1'b0;
      sdo_oe_nxt  = 1'b0;
    end
    sdo_out_nxt = tx_bit_nxt;
  end

  // Register all state and pad drives
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= S_IDLE;
      cnt_r     <= 4'h0;
      ack_r     <= 1'b0;
      sh_r      <= 8'h00;
      ptr_r     <= 7'h00;
      rw_r      <= 1'b0;
      hdr_r     <= 1'b0;
      nak_r     <= 1'b0;
      tx_en_r   <= 1'b0;
      tx_bit_r  <= 1'b0;
      rd_strobe <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      sdo_out   <= 1'b0;
      sdo_oe    <= 1'b0;
      ctrl1_r   <= `CTRL_ONE_RESET;
      ctrl2_r   <= `CTRL_TWO_RESET;
      buf_r[0]  <= '0;
      buf_r[1]  <= '0;
      head_r    <= 1'b0;
      count_r   <= 2'h0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      ack_r     <= ack_nxt;
      sh_r      <= sh_nxt;
      ptr_r     <= ptr_nxt;
      rw_r      <= rw_nxt;
      hdr_r     <= hdr_nxt;
      nak_r     <= nak_nxt;
      tx_en_r   <= tx_en_nxt;
      tx_bit_r  <= tx_bit_nxt;
      rd_strobe <= strobe_nxt;
      sda_out   <= sda_out_nxt;
      sda_oe    <= sda_oe_nxt;
      sdo_out   <= sdo_out_nxt;
      sdo_oe    <= sdo_oe_nxt;
      ctrl1_r   <= ctrl1_nxt;
      ctrl2_r   <= ctrl2_nxt;
      buf_r     <= buf_nxt;
      head_r    <= head_nxt;
      count_r   <= count_nxt;
    end
  end

  // Address the user side must answer for
  assign rd_addr = ptr_r;

endmodule
`default_nettype wire

// ===== include/serial_port_defines.svh
// Constants of the dual I2C / SPI register access port
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

`define I2C_ADDR_UPPER     6'h2E
`define CTRL_ONE_ADDR      7'h10
`define CTRL_TWO_ADDR      7'h11
`define CTRL_ONE_RESET     8'h00
`define CTRL_TWO_RESET     8'h10
`define THREE_WIRE_BIT     0
`define AUTO_INC_BIT       4
`define BYTE_BITS          4'h8
`define BUF_DEPTH          2'h2

`endif

// ===== include/serial_port_pkg.sv
// Types shared by the serial register port
`default_nettype none
package serial_port_pkg;

  // One-hot protocol states
  typedef enum logic [5:0] {
    S_IDLE     = 6'h01,
    S_I2C_ADDR = 6'h02,
    S_I2C_PTR  = 6'h04,
    S_I2C_WR   = 6'h08,
    S_I2C_RD   = 6'h10,
    S_SPI      = 6'h20
  } port_state_t;

  // Buffered register write: address and byte
  typedef logic [14:0] wr_word_t;

endpackage
`default_nettype wire

// ===== testbench/dual_serial_register_port_checker.sv
// Pin-level assertions for the dual serial register port
`timescale 1ns/1ps
`default_nettype none
module dual_serial_register_port_checker (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       cs_pin,
  input wire logic       scl_pin,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       sdo_oe,
  input wire logic       rd_strobe,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       three_wire_select
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Six cycles allow for the pad synchroniser and output flop
  sequence cs_hi6;
    cs_pin [*6];
  endsequence
  // Settled I2C clock high phase
  sequence scl_hi4;
    (cs_pin && scl_pin) [*4];
  endsequence
  a_sdo_idle_i2c: assert property (cs_hi6 |-> !sdo_oe)
    else $error("SERIAL_DATA_OUT driven while in I2C mode");
  a_sda_open_drain: assert property (cs_hi6 ##0 sda_oe |-> !sda_out)
    else $error("SDA driven high in I2C mode");
  a_three_wire_sdo: assert property (three_wire_select |-> !sdo_oe)
    else $error("SERIAL_DATA_OUT driven in 3-wire mode");
  a_four_wire_sda: assert property (!cs_pin [*6] ##0 !three_wire_select |-> !sda_oe)
    else $error("Data pin driven in 4-wire mode");
  a_strobe_single: assert property (rd_strobe |=> !rd_strobe)
    else $error("Read strobe longer than a cycle");
  a_buffer_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("Write entry lost during stall");
  a_cs_release: assert property ($rose(cs_pin) ##0 cs_hi6 |-> !sdo_oe && !sda_oe)
    else $error("Pads still driven after deselect");
  a_ack_hold: assert property (scl_hi4 ##0 sda_oe |=> sda_oe)
    else $error("SDA released during SCL high");
endmodule
bind dual_serial_register_port dual_serial_register_port_checker dual_serial_register_port_checker_inst (
  .sys_clk, .rst_b, .cs_pin, .scl_pin, .sda_out, .sda_oe, .sdo_oe, .rd_strobe,
  .wr_valid, .wr_ready, .wr_addr, .wr_data, .three_wire_select);
`default_nettype wire

// ===== testbench/serial_host_model.sv
// Host bus master model driving SPI and I2C pins
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input  wire logic sys_clk,
  input  wire logic sda_in,
  input  wire logic sdo_in,
  output var  logic cs_pin,
  output var  logic scl_pin,
  output var  logic m_sda,
  output var  logic m_oe
);
  logic w3;  // Read from shared pin
  initial begin
    cs_pin = 1'b1;  // Deselected, clock parked high
    scl_pin = 1'b1;
    m_sda = 1'b1;
    m_oe = 1'b1;
    w3 = 1'b0;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task begin_spi(input logic three);
    w3 = three;
    cs_pin <= 1'b0;  // Held low for the whole frame
    tick(4);
  endtask
  // Change on fall, sample in high phase; 3-wire reads release the pin
  task spi_byte(input logic [7:0] b, input logic rd, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      scl_pin <= 1'b0;
      m_sda <= b[i];
      m_oe <= !(w3 && rd);
      tick(4);
      scl_pin <= 1'b1;
      tick(2);
      r[i] = w3 ? sda_in : sdo_in;
      tick(2);
    end
  endtask
  task end_spi;
    cs_pin <= 1'b1;
    m_oe <= 1'b1;
    tick(8);
  endtask
  // 64 cycles a bit keeps under 400 kHz
  task i2c_bit(input logic b, output logic r);
    m_sda <= b;
    tick(16);
    scl_pin <= 1'b1;
    tick(16);
    r = sda_in;
    tick(16);
    scl_pin <= 1'b0;
    tick(16);
  endtask
  // Data falls with clock high, also serves as restart
  task i2c_start;
    m_sda <= 1'b1;
    tick(16);
    scl_pin <= 1'b1;
    tick(16);
    m_sda <= 1'b0;
    tick(16);
    scl_pin <= 1'b0;
    tick(16);
  endtask
  task i2c_stop;
    m_sda <= 1'b0;
    tick(16);
    scl_pin <= 1'b1;
    tick(16);
    m_sda <= 1'b1;
    tick(32);
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task i2c_byte(input logic [7:0] b, input logic a, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--)
      i2c_bit(b[i], r[i]);
    i2c_bit(a, ak);
  endtask
endmodule
`default_nettype wire

// ===== testbench/dual_serial_register_port_tb_top.sv
// Self-checking bench of the dual serial register port
`timescale 1ns/1ps
`default_nettype none
module dual_serial_register_port_tb_top;
  logic       sys_clk, rst_b, cs_pin, scl_pin, m_sda, m_oe, sda_in, sdo_in, lsb;
  logic       sda_out, sda_oe, sdo_out, sdo_oe, rd_strobe, wr_valid, wr_ready;
  logic       three_wire_select, addr_auto_increment, ak;
  logic [6:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data, r0;
  int         error_cnt, n_checks;
  int         n_strobe;    // Read strobes seen so far
  // Wired-AND pad with pull-up
  assign sda_in = (sda_oe ? sda_out : 1'b1) & (m_oe ? m_sda : 1'b1);
  assign sdo_in = sdo_oe ? sdo_out : lsb;
  assign rd_data = f(rd_addr);
  dual_serial_register_port dual_serial_register_port_inst (.sys_clk, .rst_b, .cs_pin, .scl_pin,
    .sda_in, .sda_out, .sda_oe, .sdo_in, .sdo_out, .sdo_oe, .rd_addr, .rd_data, .rd_strobe,
    .wr_valid, .wr_ready, .wr_addr, .wr_data, .three_wire_select, .addr_auto_increment);
  serial_host_model serial_host_model_inst (.sys_clk, .sda_in, .sdo_in, .cs_pin, .scl_pin, .m_sda, .m_oe);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Count one-cycle read strobes so bursts can be checked per byte
  always @(posedge sys_clk) begin
    if (rd_strobe === 1'b1) begin
      n_strobe <= n_strobe + 1;
    end
  end
  // Register contents seen by the port
  function automatic logic [7:0] f(input logic [6:0] a);
    return {1'b0, a} ^ 8'h5A;
  endfunction
  task results;
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t ns: value differs", $time);
    end
  endtask
  // Wait for a buffered write and accept it
  task pop(input logic [6:0] a, input logic [7:0] d);
    int k;
    k = 0;
    while (wr_valid !== 1'b1 && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 400) begin
      error_cnt++;
      $display("Error at %0t ns: no buffered write offered", $time);
      results;
    end
    chk(wr_addr === a && wr_data === d);
    wr_ready <= 1'b1;
    @(posedge sys_clk);
    wr_ready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task sb(input logic [7:0] b, input logic rd);
    serial_host_model_inst.spi_byte(b, rd, r0);
  endtask
  task ib(input logic [7:0] b, input logic a);
    serial_host_model_inst.i2c_byte(b, a, r0, ak);
  endtask
  task spi_wr(input logic [6:0] a, input logic [7:0] d, input logic w);
    serial_host_model_inst.begin_spi(w);
    sb({1'b0, a}, 1'b0);
    sb(d, 1'b0);
    serial_host_model_inst.end_spi;
    pop(a, d);
  endtask
  task spi_rd(input logic [6:0] a, input logic w, input logic [7:0] e1);
    int s0;
    s0 = n_strobe;
    serial_host_model_inst.begin_spi(w);
    sb({1'b1, a}, 1'b0);
    sb(8'hFF, 1'b1);
    chk(r0 === f(a));
    sb(8'hFF, 1'b1);
    chk(r0 === e1);
    serial_host_model_inst.end_spi;
    chk(n_strobe == s0 + 2);
  endtask
  // Stalled receiver: buffer fills, third byte is lost
  task t_spi_fill;
    serial_host_model_inst.begin_spi(1'b0);
    sb(8'h20, 1'b0);
    sb(8'hA5, 1'b0);
    sb(8'h3C, 1'b0);
    sb(8'h11, 1'b0);
    serial_host_model_inst.end_spi;
    pop(7'h20, 8'hA5);
    pop(7'h21, 8'h3C);
    chk(wr_valid === 1'b0);
  endtask
  // Auto-increment off with a 4-wire burst read, then on with a 3-wire burst read
  task t_spi_modes;
    spi_wr(7'h11, 8'h00, 1'b0);
    chk(addr_auto_increment === 1'b0);
    spi_rd(7'h30, 1'b0, f(7'h30));
    spi_wr(7'h11, 8'h10, 1'b0);
    spi_wr(7'h10, 8'h01, 1'b0);
    chk(three_wire_select === 1'b1);
    spi_rd(7'h40, 1'b1, f(7'h41));
    spi_wr(7'h10, 8'h00, 1'b1);
    chk(three_wire_select === 1'b0);
  endtask
  // Address match for both pad levels
  task t_i2c_addr;
    for (int s = 0; s < 2; s++) begin
      lsb <= s[0];
      repeat (8) @(posedge sys_clk);
      for (int a = 0; a < 2; a++) begin
        serial_host_model_inst.i2c_start;
        ib({6'h2E, a[0], 1'b0}, 1'b1);
        chk(ak === (a != s));
        serial_host_model_inst.i2c_stop;
      end
    end
  endtask
  // Pointer top bit ignored, then restart and two-byte read
  task t_i2c_xfer;
    serial_host_model_inst.i2c_start;
    ib(8'hBA, 1'b1);
    chk(ak === 1'b0);
    ib(8'hC5, 1'b1);
    ib(8'h77, 1'b1);
    chk(ak === 1'b0);
    serial_host_model_inst.i2c_stop;
    pop(7'h45, 8'h77);
    serial_host_model_inst.i2c_start;
    ib(8'hBA, 1'b1);
    ib(8'h22, 1'b1);
    serial_host_model_inst.i2c_start;
    ib(8'hBB, 1'b1);
    chk(ak === 1'b0);
    ib(8'hFF, 1'b0);
    chk(r0 === f(7'h22));
    ib(8'hFF, 1'b1);
    chk(r0 === f(7'h23));
    serial_host_model_inst.i2c_stop;
  endtask
  // Stalled receiver on I2C: third byte gets no acknowledge
  task t_i2c_fill;
    serial_host_model_inst.i2c_start;
    ib(8'hBA, 1'b1);
    ib(8'h50, 1'b1);
    ib(8'h01, 1'b1);
    chk(ak === 1'b0);
    ib(8'h02, 1'b1);
    chk(ak === 1'b0);
    ib(8'h03, 1'b1);
    chk(ak === 1'b1);
    serial_host_model_inst.i2c_stop;
    pop(7'h50, 8'h01);
    pop(7'h51, 8'h02);
    chk(wr_valid === 1'b0);
  endtask
  initial begin
    rst_b = 1'b0;
    wr_ready = 1'b0;
    lsb = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(addr_auto_increment === 1'b1 && three_wire_select === 1'b0 && wr_valid === 1'b0);
    t_spi_fill;
    t_spi_modes;
    t_i2c_addr;
    t_i2c_xfer;
    t_i2c_fill;
    results;
  end
endmodule
`default_nettype wire
